// *** serial_flash_command_engine.sv ***
`timescale 1ns/100ps
// Notes on behaviour
// - eight-byte command, response buffers, length register
// - trigger drops chip select, starts clocking
// - eight clocks per counted byte, then stop
// - after first byte, capture input into responses
// - bytes past command buffer send don't-care
// - software commands usable without flash execution
// - data-space reads run automatically in hardware
// - erase: opcode, three address bytes, length four
// - erase: 32 bits out, input ignored, deselect
// - program: opcode, address, data, length five
// - single opcode commands use length one
// - identification: opcode, length four, dummies follow
// - identification leaves three bytes, then deselect
// - interface enabled after reset; disable input
// - fast read: 0x0b, address, dummy, sequential data
module serial_flash_command_engine
  import flash_cmd_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input  wire logic             clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             link_clk_in,
  input  wire logic             cmd_wr_in,
  input  wire logic [IDX_W-1:0] cmd_idx_in,
  input  wire logic [7:0]       cmd_data_in,
  input  wire logic             len_wr_in,
  input  wire logic [LEN_W-1:0] len_data_in,
  input  wire logic             go_set_in,
  input  wire logic             flash_disable_in,
  input  wire logic [IDX_W-1:0] resp_idx_in,
  input  wire logic             ext_rd_req_in,
  input  wire logic [23:0]      ext_rd_addr_in,
  input  wire logic             flash_serial_in,
  output logic                  go_out,
  output logic [7:0]            resp_data_out,
  output logic [LEN_W-1:0]      len_out,
  output logic                  ext_rd_busy_out,
  output logic                  ext_rd_ack_out,
  output logic [7:0]            ext_rd_data_out,
  output logic                  flash_cs_n_out,
  output logic                  flash_sclk_out,
  output logic                  flash_so_out
);
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_SW    = 2'b01,
    M_RD    = 2'b10,
    M_CLOSE = 2'b11
  } main_state_t;

  // system domain state
  main_state_t      state_q;
  byte_buf_t        cmd_buf_q;
  byte_buf_t        resp_buf_q;
  logic [LEN_W-1:0] len_q;
  logic             go_q;
  logic             rd_pend_q;
  logic [23:0]      rd_addr_q;
  logic [23:0]      last_addr_q;
  logic             cs_held_q;
  logic             rd_cont_q;
  logic             req_tgl_q;
  flash_job_t       job_q;
  logic             ack_seen_q;

  // crossing signals
  logic             link_rst_n;
  logic             req_link_sync;
  logic             serial_in_sync;
  logic             ack_tgl_link;
  logic             ack_sync;
  byte_buf_t        resp_link;

  // link domain reset: asserted at once, released on the link clock
  bit_sync2 u_link_rst (
    .clk_in    (link_clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (1'b1),
    .q_out     (link_rst_n)
  );

  // job request toggle into the link domain
  bit_sync2 u_req_sync (
    .clk_in    (link_clk_in),
    .arst_n_in (link_rst_n),
    .d_in      (req_tgl_q),
    .q_out     (req_link_sync)
  );

  // data in pin into the link domain
  bit_sync2 u_si_sync (
    .clk_in    (link_clk_in),
    .arst_n_in (link_rst_n),
    .d_in      (flash_serial_in),
    .q_out     (serial_in_sync)
  );

  // job done toggle back into the system domain
  bit_sync2 u_ack_sync (
    .clk_in    (clk_in),
    .arst_n_in (arst_n_in),
    .d_in      (ack_tgl_link),
    .q_out     (ack_sync)
  );

  // serial engine on the link clock
  flash_link_shifter #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_shifter (
    .clk_in            (link_clk_in),
    .arst_n_in         (link_rst_n),
    .req_sync_in       (req_link_sync),
    .job_in            (job_q),
    .serial_in_sync_in (serial_in_sync),
    .cs_n_out          (flash_cs_n_out),
    .sclk_out          (flash_sclk_out),
    .so_out            (flash_so_out),
    .resp_out          (resp_link),
    .ack_tgl_out       (ack_tgl_link)
  );

  // request and completion decode
  wire ack_edge   = ack_sync ^ ack_seen_q;
  wire idle       = (state_q == M_IDLE);
  wire cfg_open   = !go_q;
  wire go_take    = go_set_in && !go_q && !flash_disable_in;
  wire rd_take    = ext_rd_req_in && !rd_pend_q && !flash_disable_in;
  wire seq_hit    = cs_held_q && (rd_addr_q == last_addr_q + ADDR_STEP);
  wire start_rd   = idle && rd_pend_q && !flash_disable_in &&
                    (seq_hit || !cs_held_q);
  wire start_sw   = idle && go_q && !rd_pend_q && !cs_held_q &&
                    !flash_disable_in;
  wire start_cls  = idle && cs_held_q &&
                    (flash_disable_in || (rd_pend_q && !seq_hit) ||
                     (go_q && !rd_pend_q));
  wire [7:0] rd_byte = resp_link[rd_cont_q ? NEXT_DATA_IDX : FAST_DATA_IDX];

  // software job: the buffer as loaded, deselect at the end
  flash_job_t sw_job;
  assign sw_job.tx        = cmd_buf_q;
  assign sw_job.nbytes    = len_q;
  assign sw_job.hold_cs   = 1'b0;
  assign sw_job.cap_first = 1'b0;

  // read job: full fast read, or one more byte on a sequential hit
  flash_job_t rd_job;
  assign rd_job.tx = seq_hit ? byte_buf_t'({BUF_BYTES{DUMMY_BYTE}}) :
                     byte_buf_t'({DUMMY_BYTE, DUMMY_BYTE, DUMMY_BYTE,
                                  DUMMY_BYTE, rd_addr_q[7:0],
                                  rd_addr_q[15:8], rd_addr_q[23:16],
                                  OP_FAST_READ});
  assign rd_job.nbytes    = seq_hit ? LEN_FAST_NEXT : LEN_FAST_READ;
  assign rd_job.hold_cs   = 1'b1;
  assign rd_job.cap_first = seq_hit;

  // close job: no clocks, only returns chip select high
  flash_job_t close_job;
  assign close_job.tx        = '0;
  assign close_job.nbytes    = LEN_CLOSE;
  assign close_job.hold_cs   = 1'b0;
  assign close_job.cap_first = 1'b0;

  // command buffer and length, writable only while the trigger bit is clear
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cmd_buf_q <= '0;
      len_q     <= LEN_RESET;
    end else begin
      if (cmd_wr_in && cfg_open) begin
        cmd_buf_q[cmd_idx_in] <= cmd_data_in;
      end
      if (len_wr_in && cfg_open) begin
        len_q <= len_data_in;
      end
    end
  end

  // trigger bit: set by software, cleared by completion
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      go_q <= 1'b0;
    end else if (go_take) begin
      go_q <= 1'b1;
    end else if (ack_edge && state_q == M_SW) begin
      go_q <= 1'b0;
    end
  end

  // hardware read request capture
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else if (rd_take) begin
      rd_pend_q <= 1'b1;
      rd_addr_q <= ext_rd_addr_in;
    end else if (ack_edge && state_q == M_RD) begin
      rd_pend_q <= 1'b0;
    end
  end

  // arbitration: reads first, chip select closed before others
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q   <= M_IDLE;
      req_tgl_q <= 1'b0;
      job_q     <= '0;
      rd_cont_q <= 1'b0;
    end else begin
      unique case (state_q)
        M_IDLE: begin
          if (start_cls) begin
            job_q     <= close_job;
            req_tgl_q <= ~req_tgl_q;
            state_q   <= M_CLOSE;
          end else if (start_rd) begin
            job_q     <= rd_job;
            rd_cont_q <= seq_hit;
            req_tgl_q <= ~req_tgl_q;
            state_q   <= M_RD;
          end else if (start_sw) begin
            job_q     <= sw_job;
            req_tgl_q <= ~req_tgl_q;
            state_q   <= M_SW;
          end
        end
        M_SW, M_RD, M_CLOSE: begin
          if (ack_edge) begin
            state_q <= M_IDLE;
          end
        end
      endcase
    end
  end

  // completion bookkeeping: responses, held select, read data
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ack_seen_q      <= 1'b0;
      resp_buf_q      <= '0;
      cs_held_q       <= 1'b0;
      last_addr_q     <= '0;
      ext_rd_ack_out  <= 1'b0;
      ext_rd_data_out <= '0;
    end else begin
      ack_seen_q     <= ack_sync;
      ext_rd_ack_out <= 1'b0;
      if (ack_edge) begin
        unique case (state_q)
          M_SW: begin
            resp_buf_q <= resp_link;
          end
          M_RD: begin
            ext_rd_ack_out  <= 1'b1;
            ext_rd_data_out <= rd_byte;
            last_addr_q     <= rd_addr_q;
            cs_held_q       <= 1'b1;
          end
          M_CLOSE: begin
            cs_held_q <= 1'b0;
          end
          M_IDLE: begin
            cs_held_q <= cs_held_q;
          end
        endcase
      end
    end
  end

  // registered status and read-back outputs
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      go_out          <= 1'b0;
      resp_data_out   <= '0;
      len_out         <= LEN_RESET;
      ext_rd_busy_out <= 1'b0;
    end else begin
      go_out          <= go_q || go_take;
      resp_data_out   <= resp_buf_q[resp_idx_in];
      len_out         <= len_q;
      ext_rd_busy_out <= rd_pend_q || rd_take;
    end
  end

  // the disable input gates every new software and read job and starts a close of a held select; reset leaves it enabled
  // when the input is low, which is the state after reset

endmodule : serial_flash_command_engine

// *** flash_cmd_pkg.sv ***
package flash_cmd_pkg;

  // buffer geometry
  localparam int BUF_BYTES = 8;
  localparam int LEN_W     = 4;
  localparam int IDX_W     = 3;

  // opcodes that software or the read path places in byte 0
  localparam logic [7:0] OP_SECTOR_ERASE   = 8'h20;
  localparam logic [7:0] OP_BLOCK32K_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64K_ERASE = 8'hd8;
  localparam logic [7:0] OP_BYTE_PROGRAM   = 8'h02;
  localparam logic [7:0] OP_READ_ID        = 8'h9f;
  localparam logic [7:0] OP_FAST_READ      = 8'h0b;
  localparam logic [7:0] DUMMY_BYTE        = 8'h00;

  // transfer lengths in bytes for the documented sequences
  localparam logic [LEN_W-1:0] LEN_ERASE      = 4'h4;
  localparam logic [LEN_W-1:0] LEN_PROGRAM    = 4'h5;
  localparam logic [LEN_W-1:0] LEN_SINGLE     = 4'h1;
  localparam logic [LEN_W-1:0] LEN_READ_ID    = 4'h4;
  localparam logic [LEN_W-1:0] LEN_FAST_READ  = 4'h6;
  localparam logic [LEN_W-1:0] LEN_FAST_NEXT  = 4'h1;
  localparam logic [LEN_W-1:0] LEN_CLOSE      = 4'h0;
  localparam logic [IDX_W-1:0] FAST_DATA_IDX  = 3'h4;
  localparam logic [IDX_W-1:0] NEXT_DATA_IDX  = 3'h0;
  localparam logic [23:0]      ADDR_STEP      = 24'h000001;

  // reset values
  localparam logic [LEN_W-1:0] LEN_RESET  = 4'h0;
  localparam logic             CS_N_RESET = 1'b1;
  localparam logic             SCLK_RESET = 1'b0;

  // link clock cycles per serial clock half period (at least 2)
  localparam int LINK_HALF_CYCLES = 2;

  typedef logic [BUF_BYTES-1:0][7:0] byte_buf_t;

  // one job handed from the system domain to the link domain
  typedef struct packed {
    byte_buf_t        tx;
    logic [LEN_W-1:0] nbytes;
    logic             hold_cs;
    logic             cap_first;
  } flash_job_t;

  // outgoing bit, msb first; bytes past the buffer send zero
  function automatic logic tx_bit(input byte_buf_t        b,
                                  input logic [LEN_W-1:0] byte_idx,
                                  input logic [2:0]       bit_idx);
    logic [7:0] cur;
    cur = b[byte_idx[IDX_W-1:0]];
    if (byte_idx >= 4'(BUF_BYTES)) begin
      return 1'b0;
    end
    return cur[3'h7 - bit_idx];
  endfunction : tx_bit

endpackage : flash_cmd_pkg

// *** bit_sync2.sv ***
`timescale 1ns/100ps
module bit_sync2 (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic meta_q;

  // two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      meta_q <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end
endmodule : bit_sync2

// *** flash_link_shifter.sv ***
`timescale 1ns/100ps
module flash_link_shifter
  import flash_cmd_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic req_sync_in,
  input  flash_job_t job_in,
  input  wire logic serial_in_sync_in,
  output logic      cs_n_out,
  output logic      sclk_out,
  output logic      so_out,
  output byte_buf_t resp_out,
  output logic      ack_tgl_out
);
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_LOW  = 2'b01,
    SH_HIGH = 2'b10,
    SH_END  = 2'b11
  } shift_state_t;

  shift_state_t     state_q;
  flash_job_t       job_q;
  logic             req_seen_q;
  logic [LEN_W-1:0] byte_q;
  logic [2:0]       bit_q;
  logic [7:0]       half_q;
  logic [7:0]       rx_q;

  // decode of the current position
  wire              req_new   = req_sync_in ^ req_seen_q;
  wire              half_end  = (half_q == 8'(HALF_CYCLES - 1));
  wire [7:0]        rx_next   = {rx_q[6:0], serial_in_sync_in};
  wire [LEN_W-1:0]  byte_nx   = byte_q + 4'h1;
  wire              last_byte = (byte_nx == job_q.nbytes);
  wire [LEN_W-1:0]  cap_idx   = job_q.cap_first ? byte_q : byte_q - 4'h1;
  wire              cap_ok    = (job_q.cap_first || byte_q != 4'h0) &&
                                (cap_idx < 4'(BUF_BYTES));

  // serial master: clock idles low, out on fall, input captured on fall
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q     <= SH_IDLE;
      job_q       <= '0;
      req_seen_q  <= 1'b0;
      byte_q      <= '0;
      bit_q       <= '0;
      half_q      <= '0;
      rx_q        <= '0;
      cs_n_out    <= CS_N_RESET;
      sclk_out    <= SCLK_RESET;
      so_out      <= 1'b0;
      resp_out    <= '0;
      ack_tgl_out <= 1'b0;
    end else begin
      req_seen_q <= req_sync_in;
      unique case (state_q)
        SH_IDLE: if (req_new) begin
          job_q    <= job_in;
          byte_q   <= '0;
          bit_q    <= '0;
          half_q   <= '0;
          resp_out <= '0;
          if (job_in.nbytes == LEN_CLOSE) begin
            cs_n_out    <= 1'b1;
            ack_tgl_out <= ~ack_tgl_out;
          end else begin
            cs_n_out <= 1'b0;
            so_out   <= tx_bit(job_in.tx, 4'h0, 3'h0);
            state_q  <= SH_LOW;
          end
        end
        SH_LOW: if (half_end) begin
          half_q   <= '0;
          sclk_out <= 1'b1;
          state_q  <= SH_HIGH;
        end else begin
          half_q <= half_q + 8'h01;
        end
        SH_HIGH: if (half_end) begin
          half_q   <= '0;
          sclk_out <= 1'b0;
          rx_q     <= rx_next;
          state_q  <= SH_LOW;
          if (bit_q == 3'h7) begin
            if (cap_ok) begin
              resp_out[cap_idx[IDX_W-1:0]] <= rx_next;
            end
            if (last_byte) begin
              state_q <= SH_END;
            end else begin
              byte_q <= byte_nx;
              bit_q  <= 3'h0;
              so_out <= tx_bit(job_q.tx, byte_nx, 3'h0);
            end
          end else begin
            bit_q  <= bit_q + 3'h1;
            so_out <= tx_bit(job_q.tx, byte_q, bit_q + 3'h1);
          end
        end else begin
          half_q <= half_q + 8'h01;
        end
        SH_END: if (half_end) begin
          half_q      <= '0;
          cs_n_out    <= ~job_q.hold_cs;
          ack_tgl_out <= ~ack_tgl_out;
          state_q     <= SH_IDLE;
        end else begin
          half_q <= half_q + 8'h01;
        end
      endcase
    end
  end
endmodule : flash_link_shifter

// *** flash_cmd_asserts.sv ***
`timescale 1ns/100ps
module flash_cmd_asserts
  import flash_cmd_pkg::*;
#(
  parameter int HALF_CYCLES = LINK_HALF_CYCLES
) (
  input wire logic             clk_in,
  input wire logic             arst_n_in,
  input wire logic             link_clk_in,
  input wire logic             len_wr_in,
  input wire logic [LEN_W-1:0] len_data_in,
  input wire logic             go_set_in,
  input wire logic             flash_disable_in,
  input wire logic             go_out,
  input wire logic [LEN_W-1:0] len_out,
  input wire logic             ext_rd_busy_out,
  input wire logic             ext_rd_ack_out,
  input wire logic             flash_cs_n_out,
  input wire logic             flash_sclk_out,
  input wire logic             flash_so_out
);
  logic [7:0] hi_cnt_q;

  // length of the current high phase of the serial clock
  always_ff @(posedge link_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_cnt_q <= 8'h00;
    end else begin
      hi_cnt_q <= flash_sclk_out ? hi_cnt_q + 8'h01 : 8'h00;
    end
  end

  // a trigger that the engine must accept
  sequence s_go_take;
    go_set_in && !go_out && !flash_disable_in;
  endsequence

  a_go_taken: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    s_go_take |=> go_out) else $error("trigger not accepted");
  a_disable_blocks: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    go_set_in && flash_disable_in && !go_out |=> !go_out)
    else $error("trigger accepted while disabled");
  a_go_held: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    go_out && !flash_cs_n_out |=> go_out) else $error("trigger cleared early");
  a_go_bounded: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $rose(go_out) |-> ##[1:100] !go_out) else $error("transfer never ends");
  a_len_write: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    len_wr_in && !go_out && !go_set_in |=>
    ##1 len_out == $past(len_data_in, 2))
    else $error("length write lost");
  a_len_frozen: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    go_out |=> $stable(len_out)) else $error("length changed while busy");
  a_ack_pulse: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    ext_rd_ack_out |=> !ext_rd_ack_out) else $error("read ack too long");
  a_read_bounded: assert property (@(posedge clk_in)
    disable iff (!arst_n_in)
    $rose(ext_rd_busy_out) |-> ##[1:120] ext_rd_ack_out)
    else $error("read never answered");
  a_cs_cause: assert property (@(posedge clk_in) disable iff (!arst_n_in)
    $fell(flash_cs_n_out) |-> go_out || ext_rd_busy_out)
    else $error("select without request");
  a_sclk_idle: assert property (@(posedge link_clk_in)
    disable iff (!arst_n_in)
    flash_cs_n_out |-> !flash_sclk_out) else $error("clock while deselected");
  a_so_on_fall: assert property (@(posedge link_clk_in)
    disable iff (!arst_n_in)
    flash_sclk_out && $past(flash_sclk_out) |-> $stable(flash_so_out))
    else $error("data moved while clock high");
  a_half_period: assert property (@(posedge link_clk_in)
    disable iff (!arst_n_in)
    $fell(flash_sclk_out) |-> hi_cnt_q == 8'(HALF_CYCLES))
    else $error("wrong clock high time");
endmodule : flash_cmd_asserts

// *** flash_chip_model.sv ***
`timescale 1ns/100ps
module flash_chip_model
  import flash_cmd_pkg::*;
#(
  parameter logic [2:0][7:0] ID_BYTES = 24'h000000
) (
  input  wire logic        cs_n_in,
  input  wire logic        sclk_in,
  input  wire logic        si_in,
  output logic             so_out,
  output logic [15:0][7:0] rx_out,
  output logic [7:0]       nbits_out,
  output logic [15:0]      rises_out
);
  logic [7:0] sh;
  logic [7:0] cur;

  // answer for frame byte k: identity, read data or a count pattern
  function automatic logic [7:0] reply(input logic [4:0] k);
    if (rx_out[0] == OP_READ_ID && k >= 5'h01 && k <= 5'h03) begin
      return ID_BYTES[2'(k - 5'h01)];
    end
    if (rx_out[0] == OP_FAST_READ && k >= 5'h05) begin
      return (rx_out[3] + 8'(k - 5'h05)) ^ 8'h3c;
    end
    return 8'hc0 + 8'(k);
  endfunction : reply

  initial begin
    so_out    = 1'b0;
    rx_out    = '0;
    nbits_out = 8'h00;
    rises_out = 16'h0000;
    sh        = 8'h00;
    cur       = 8'h00;
  end

  // new frame restarts the count; a released line shows inverted level
  always @(negedge cs_n_in) begin
    nbits_out = 8'h00;
    so_out    = ~so_out;
  end
  always @(posedge cs_n_in) so_out = ~so_out;

  // take bits msb first on the rising edge, log whole bytes
  always @(posedge sclk_in) begin
    if (!cs_n_in) begin
      sh        = {sh[6:0], si_in};
      nbits_out = nbits_out + 8'h01;
      rises_out = rises_out + 16'h0001;
      if (nbits_out[2:0] == 3'h0 && nbits_out[7:3] <= 5'h10) begin
        rx_out[4'(nbits_out[7:3] - 5'h01)] = sh;
      end
    end
  end

  // drive the reply msb first after each falling edge
  always @(negedge sclk_in) begin
    if (!cs_n_in) begin
      if (nbits_out[2:0] == 3'h0) begin
        cur = reply(nbits_out[7:3]);
      end
      so_out = cur[3'h7 - nbits_out[2:0]];
    end
  end
endmodule : flash_chip_model

// *** serial_flash_command_engine_test.sv ***
`timescale 1ns/100ps
module serial_flash_command_engine_test
  import flash_cmd_pkg::*;
;
  // identity bytes are arbitrary
  localparam logic [2:0][7:0] TB_ID = 24'h332211;
  localparam logic [2:0][7:0] ERASE_OPS =
    {OP_BLOCK64K_ERASE, OP_BLOCK32K_ERASE, OP_SECTOR_ERASE};
  logic             clk_in, link_clk_in, arst_n_in, cmd_wr_in;
  logic             len_wr_in, go_set_in, flash_disable_in, ext_rd_req_in;
  logic             flash_serial_in, go_out, ext_rd_busy_out, ext_rd_ack_out;
  logic             flash_cs_n_out, flash_sclk_out, flash_so_out;
  logic [IDX_W-1:0] cmd_idx_in, resp_idx_in;
  logic [LEN_W-1:0] len_data_in, len_out;
  logic [7:0]       cmd_data_in, resp_data_out, ext_rd_data_out, nbits;
  logic [23:0]      ext_rd_addr_in;
  logic [15:0][7:0] rx;
  logic [15:0]      rises, r0;
  int               errors, num_checks;
  byte_buf_t        b;

  serial_flash_command_engine #(.HALF_CYCLES(2)) i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .link_clk_in(link_clk_in),
    .cmd_wr_in(cmd_wr_in), .cmd_idx_in(cmd_idx_in),
    .cmd_data_in(cmd_data_in), .len_wr_in(len_wr_in),
    .len_data_in(len_data_in), .go_set_in(go_set_in),
    .flash_disable_in(flash_disable_in), .resp_idx_in(resp_idx_in),
    .ext_rd_req_in(ext_rd_req_in), .ext_rd_addr_in(ext_rd_addr_in),
    .flash_serial_in(flash_serial_in), .go_out(go_out),
    .resp_data_out(resp_data_out), .len_out(len_out),
    .ext_rd_busy_out(ext_rd_busy_out), .ext_rd_ack_out(ext_rd_ack_out),
    .ext_rd_data_out(ext_rd_data_out), .flash_cs_n_out(flash_cs_n_out),
    .flash_sclk_out(flash_sclk_out), .flash_so_out(flash_so_out));

  flash_chip_model #(.ID_BYTES(TB_ID)) i_flash (
    .cs_n_in(flash_cs_n_out), .sclk_in(flash_sclk_out),
    .si_in(flash_so_out), .so_out(flash_serial_in), .rx_out(rx),
    .nbits_out(nbits), .rises_out(rises));

  // system clock 100 ns, link clock 6 ns at an unrelated phase
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  initial begin
    link_clk_in = 1'b0;
    #1.7;
    forever #3 link_clk_in = ~link_clk_in;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic expire(input int k);
    if (k >= 200) begin
      errors++;
      $display("ERROR %0t wait expired", $time);
      print_verdict();
    end
  endtask : expire

  // load buffer and length, trigger, optionally poke length while busy
  task automatic run(input byte_buf_t v, input logic [LEN_W-1:0] n,
                     input logic poke);
    int k;
    for (k = 0; k < BUF_BYTES; k++) begin
      @(posedge clk_in);
      cmd_wr_in   <= 1'b1;
      cmd_idx_in  <= IDX_W'(k);
      cmd_data_in <= v[k];
    end
    @(posedge clk_in);
    cmd_wr_in   <= 1'b0;
    len_wr_in   <= 1'b1;
    len_data_in <= n;
    @(posedge clk_in);
    len_wr_in <= 1'b0;
    go_set_in <= 1'b1;
    @(posedge clk_in);
    go_set_in   <= 1'b0;
    len_wr_in   <= poke;
    len_data_in <= 4'hf;
    @(negedge clk_in);
    chk(go_out, 1'b1);
    @(posedge clk_in);
    len_wr_in <= 1'b0;
    for (k = 0; k < 200 && go_out !== 1'b0; k++) begin
      @(negedge clk_in);
    end
    expire(k);
    chk(len_out, n);
    chk(flash_cs_n_out, 1'b1);
  endtask : run

  task automatic get_resp(input logic [IDX_W-1:0] i, input logic [7:0] e);
    @(posedge clk_in);
    resp_idx_in <= i;
    @(posedge clk_in);
    @(negedge clk_in);
    chk(resp_data_out, e);
  endtask : get_resp

  task automatic ext_rd(input logic [23:0] a);
    int k;
    @(posedge clk_in);
    ext_rd_req_in  <= 1'b1;
    ext_rd_addr_in <= a;
    @(posedge clk_in);
    ext_rd_req_in <= 1'b0;
    @(negedge clk_in);
    chk(ext_rd_busy_out, 1'b1);
    for (k = 0; k < 200 && ext_rd_ack_out !== 1'b1; k++) begin
      @(negedge clk_in);
    end
    expire(k);
    chk(ext_rd_data_out, a[7:0] ^ 8'h3c);
  endtask : ext_rd

  // main sequence
  initial begin
    {arst_n_in, cmd_wr_in, len_wr_in, go_set_in} = 4'h0;
    {flash_disable_in, ext_rd_req_in, cmd_idx_in, resp_idx_in} = '0;
    {len_data_in, cmd_data_in, ext_rd_addr_in} = '0;
    errors = 0;
    num_checks = 0;
    repeat (19) @(posedge clk_in);
    @(negedge clk_in);
    chk({go_out, len_out, flash_cs_n_out, flash_sclk_out}, 16'h0002);
    @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    get_resp(3'h0, 8'h00);
    for (int e = 0; e < 3; e++) begin
      b = '0;
      b[0] = ERASE_OPS[e];
      b[3:1] = {8'h01, 8'h23, 8'(8'h40 + e)};
      run(b, LEN_ERASE, 1'b0);
      chk(nbits, 8'h20);
      chk(rx[0], ERASE_OPS[e]);
      chk(rx[1], 8'(8'h40 + e));
    end
    b = '0;
    b[4:0] = {8'ha5, 8'h00, 8'h10, 8'h07, OP_BYTE_PROGRAM};
    run(b, LEN_PROGRAM, 1'b1);
    chk(nbits, 8'h28);
    chk(rx[4], 8'ha5);
    b = '0;
    b[0] = 8'h6c;
    run(b, LEN_SINGLE, 1'b0);
    chk(nbits, 8'h08);
    b[0] = OP_READ_ID;
    run(b, LEN_READ_ID, 1'b0);
    chk(rx[2], 8'h00);
    for (int i = 0; i < 3; i++) begin
      get_resp(IDX_W'(i), TB_ID[i]);
    end
    for (int i = 0; i < BUF_BYTES; i++) begin
      b[i] = 8'(8'h30 + i);
    end
    run(b, 4'ha, 1'b0);
    chk(nbits, 8'h50);
    chk({rx[9], rx[8]}, 16'h0000);
    get_resp(3'h0, 8'hc1);
    get_resp(3'h7, 8'hc8);
    r0 = rises;
    run(b, LEN_CLOSE, 1'b0);
    chk(rises, r0);
    @(posedge clk_in);
    flash_disable_in <= 1'b1;
    go_set_in        <= 1'b1;
    @(posedge clk_in);
    go_set_in <= 1'b0;
    repeat (3) @(negedge clk_in);
    chk({go_out, flash_cs_n_out}, 16'h0001);
    @(posedge clk_in);
    flash_disable_in <= 1'b0;
    ext_rd(24'h0012fe);
    chk({rx[0], rx[3]}, {OP_FAST_READ, 8'hfe});
    ext_rd(24'h0012ff);
    chk(nbits, 8'h38);
    ext_rd(24'h000500);
    chk(nbits, 8'h30);
    @(posedge clk_in);
    flash_disable_in <= 1'b1;
    repeat (3) @(negedge clk_in);
    chk(flash_cs_n_out, 1'b1);
    @(posedge clk_in);
    flash_disable_in <= 1'b0;
    ext_rd(24'h000501);
    chk(nbits, 8'h30);
    b[0] = 8'h6c;
    run(b, LEN_SINGLE, 1'b0);
    chk(nbits, 8'h08);
    print_verdict();
  end
endmodule : serial_flash_command_engine_test

bind serial_flash_command_engine flash_cmd_asserts #(
  .HALF_CYCLES(HALF_CYCLES)
) u_chk (
  .clk_in(clk_in), .arst_n_in(arst_n_in), .link_clk_in(link_clk_in),
  .len_wr_in(len_wr_in), .len_data_in(len_data_in), .go_set_in(go_set_in),
  .flash_disable_in(flash_disable_in), .go_out(go_out),
  .len_out(len_out), .ext_rd_busy_out(ext_rd_busy_out),
  .ext_rd_ack_out(ext_rd_ack_out), .flash_cs_n_out(flash_cs_n_out),
  .flash_sclk_out(flash_sclk_out), .flash_so_out(flash_so_out));
